// ---- src/vxc_i2c_rx.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "vxc_map.svh"

module vxc_i2c_rx (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Synchronised bus events and address straps
  input wire vxc_pkg::vxc_evt_type evt,
  input wire logic [1:0] addr_sel,
  // Received bytes and acknowledge drive
  output var vxc_pkg::vxc_byte_type rx,
  output var logic ack_drive
);

  vxc_pkg::vxc_state_type state, next_state; // Byte engine state
  logic [2:0] bit_cnt, next_bit_cnt; // Bits taken in this byte
  logic [7:0] shreg, next_shreg; // Incoming byte, MSB first
  logic [1:0] byte_idx, next_byte_idx; // 0 address, 1 register, 2 data
  logic next_ack_drive;
  vxc_pkg::vxc_byte_type next_rx;
  logic [7:0] own_addr; // Write address this device answers

  assign own_addr = {addr_sel, `VXC_ADDR_FIXED};

  // Next state of the byte engine
  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_shreg = shreg;
    next_byte_idx = byte_idx;
    next_ack_drive = ack_drive;
    next_rx = '0;
    if (evt.start) begin
      // A start, repeated or not, always opens a new address phase
      next_state = vxc_pkg::ST_RECV;
      next_bit_cnt = 3'h0;
      next_byte_idx = 2'h0;
      next_ack_drive = 1'b0;
    end else if (evt.stop) begin
      // A stop mid-byte drops the partial byte
      next_state = vxc_pkg::ST_IDLE;
      next_ack_drive = 1'b0;
    end else begin
      unique case (state)
        vxc_pkg::ST_IDLE: begin
        end
        vxc_pkg::ST_RECV: begin
          if (evt.scl_rise) begin
            next_shreg = {shreg[6:0], evt.sda};
            next_bit_cnt = bit_cnt + 3'h1;
            if (bit_cnt == 3'h7) begin
              next_state = vxc_pkg::ST_HOLD;
            end
          end
        end
        vxc_pkg::ST_HOLD: begin
          // Eight bits are in; act once the clock falls
          if (evt.scl_fall) begin
            if (byte_idx == 2'h0) begin
              // Read addresses never match: write-only port [R1] [R12]
              if (shreg == own_addr) begin
                next_state = vxc_pkg::ST_ACK;
                next_ack_drive = 1'b1; // [R14]
                next_byte_idx = 2'h1;
              end else begin
                next_state = vxc_pkg::ST_IGNORE;
              end
            end else begin
              // Whole byte only, never a partial one [R15] [R2]
              next_rx.strobe = 1'b1;
              next_rx.is_reg = (byte_idx == 2'h1);
              next_rx.data = shreg;
              next_byte_idx = 2'h2;
              next_state = vxc_pkg::ST_ACK;
              next_ack_drive = 1'b1; // [R14]
            end
          end
        end
        vxc_pkg::ST_ACK: begin
          // Hold low through the ninth high phase, release on its fall
          if (evt.scl_fall) begin
            next_ack_drive = 1'b0; // [R14]
            next_state = vxc_pkg::ST_RECV;
            next_bit_cnt = 3'h0;
          end
        end
        vxc_pkg::ST_IGNORE: begin
        end
        default: begin
          next_state = vxc_pkg::ST_IDLE;
          next_ack_drive = 1'b0;
        end
      endcase
    end
  end

  // Engine registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= vxc_pkg::ST_IDLE;
      bit_cnt <= 3'h0;
      shreg <= 8'h00;
      byte_idx <= 2'h0;
      ack_drive <= 1'b0;
      rx <= '0;
    end else begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      shreg <= next_shreg;
      byte_idx <= next_byte_idx;
      ack_drive <= next_ack_drive;
      rx <= next_rx;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_ack_hold: assert property ( // [R14]
    (ack_drive && !evt.scl_fall && !evt.start && !evt.stop) |=> ack_drive)
    else $error("acknowledge released before the ninth clock fell");

  a_ack_release: assert property ( // [R14]
    (state == vxc_pkg::ST_ACK && evt.scl_fall && !evt.start && !evt.stop)
    |=> (!ack_drive && state == vxc_pkg::ST_RECV))
    else $error("acknowledge not released after the ninth clock");

  a_addr_reject: assert property ( // [R1]
    (state == vxc_pkg::ST_HOLD && byte_idx == 2'h0 && evt.scl_fall &&
     !evt.start && !evt.stop && shreg != own_addr)
    |=> (!ack_drive && state == vxc_pkg::ST_IGNORE)[*2])
    else $error("foreign or read address was acknowledged");

endmodule // vxc_i2c_rx

`default_nettype wire

// ---- src/vxc_map.svh ----
`ifndef VXC_MAP_SVH
`define VXC_MAP_SVH

// Register offsets on the serial control port
`define VXC_OFF_ROUTE_12 8'h00
`define VXC_OFF_ROUTE_34 8'h01
`define VXC_OFF_ROUTE_56 8'h02
`define VXC_OFF_CLAMP 8'h03
`define VXC_OFF_GAIN 8'h04

// Reset values
`define VXC_RST_REG 8'h00
`define VXC_RST_GAIN 6'h00
`define VXC_RST_PWRDN 6'h3F
`define VXC_RST_PINS 4'h3

// Fixed low six bits of the slave address byte
`define VXC_ADDR_FIXED 6'h06

// Field positions and codes
`define VXC_GAIN_MSB 5
`define VXC_SEL_OFF 4'h0
`define VXC_SEL_LAST 4'h8

`endif

// ---- src/vxc_pkg.sv ----
`default_nettype none

package vxc_pkg;

  // Receiver states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RECV = 3'b001,
    ST_HOLD = 3'b010,
    ST_ACK = 3'b011,
    ST_IGNORE = 3'b100
  } vxc_state_type;

  // Bus events seen after synchronising the pins
  typedef struct packed {
    logic start;
    logic stop;
    logic scl_rise;
    logic scl_fall;
    logic sda;
  } vxc_evt_type;

  // One received byte after the slave address
  typedef struct packed {
    logic strobe;
    logic is_reg;
    logic [7:0] data;
  } vxc_byte_type;

endpackage

`default_nettype wire

// ---- src/vxc_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "vxc_map.svh"

// Contract
// [R1] Answer address 000110 plus two strap bits
// [R2] Write is register address then data byte
// [R3] Routing registers hold odd and even selectors
// [R4] Selector zero is off, one..eight pick inputs
// [R5] Many outputs may share one input
// [R6] Off selector powers the output amplifier down
// [R7] Clamp register: one bit per input, 1=clamp
// [R8] Clamp bits untouched by routing writes
// [R9] Gain register: one bit per output, 1=0dB
// [R10] Everything resets to zero, outputs powered down
// [R11] Unknown register writes are acknowledged, ignored
// [R12] Port is write only, no read back
// [R13] Master sends slave address first after start
// [R14] Acknowledge each byte low during ninth clock
// [R15] Registers change only after whole data byte
module vxc_regs (
  // System clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // Serial control pins, data line is open drain
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  // Slave address straps
  input wire logic SLAVE_ADDR_PIN_LOW,
  input wire logic SLAVE_ADDR_PIN_HIGH,
  // Per-output source selectors, index 0 is the first output
  output logic [5:0][3:0] OUT_SELECT,
  // Per-output one-hot crosspoint, bit n-1 is input n
  output logic [5:0][7:0] OUT_ROUTE,
  // Output amplifier power-down, high while off
  output logic [5:0] OUT_PWRDN,
  // Input clamp (1) or bias (0)
  output logic [7:0] IN_CLAMP,
  // Output gain, high selects 0dB, low 6dB
  output logic [5:0] OUT_GAIN_0DB
);

  // Pin synchronisers: {addr high, addr low, sda, scl}
  logic [3:0] pin_meta; // First stage, read only by pin_sync
  logic [3:0] pin_sync; // Second stage, safe to use
  logic scl_prev; // Last synchronised clock level
  logic sda_prev; // Last synchronised data level
  vxc_pkg::vxc_evt_type evt; // Edges and bus conditions
  vxc_pkg::vxc_byte_type rx; // Byte from the receiver
  logic ack_drive; // Receiver wants the data line low

  // Control registers, write only from the bus
  logic [7:0] route_select_out_1_2, next_route_select_out_1_2;
  logic [7:0] route_select_out_3_4, next_route_select_out_3_4;
  logic [7:0] route_select_out_5_6, next_route_select_out_5_6;
  logic [7:0] input_clamp_or_bias, next_input_clamp_or_bias;
  logic [5:0] output_gain_select, next_output_gain_select;
  logic [7:0] reg_ptr, next_reg_ptr; // Register address byte

  // Decoded crosspoint state, registered so outputs come from flops
  logic [5:0][3:0] next_sel;
  logic [5:0][7:0] route, next_route;
  logic [5:0] pwrdn, next_pwrdn;
  // Open-drain data value; only the enable ever moves
  logic sda_out;

  // True when the pointer names the given register
  function automatic logic reg_hit(input logic [7:0] ptr,
                                   input logic [7:0] off);
    reg_hit = (ptr == off);
  endfunction

  // Selector to one-hot input; codes above eight route nothing
  function automatic logic [7:0] sel_onehot(input logic [3:0] sel);
    sel_onehot = 8'h00;
    if (sel != `VXC_SEL_OFF && sel <= `VXC_SEL_LAST) begin
      sel_onehot = 8'(9'h001 << (sel - 4'h1)); // [R4]
    end
  endfunction

  // Two flops on every pin before any logic looks at it
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      pin_meta <= `VXC_RST_PINS;
      pin_sync <= `VXC_RST_PINS;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      pin_meta <= {SLAVE_ADDR_PIN_HIGH, SLAVE_ADDR_PIN_LOW, SDA_IN, SCL};
      pin_sync <= pin_meta;
      scl_prev <= pin_sync[0];
      sda_prev <= pin_sync[1];
    end
  end

  // Edge and condition detection on synchronised levels.
  // Clock and data share the same delay, so a data change with zero
  // hold after the clock falls is still seen after that fall.
  always_comb begin
    // Clock edges compare the second stage with its last value
    evt.scl_rise = pin_sync[0] & ~scl_prev;
    evt.scl_fall = ~pin_sync[0] & scl_prev;
    // Start: data falls while the clock stays high
    evt.start = pin_sync[0] & scl_prev & sda_prev & ~pin_sync[1];
    // Stop: data rises while the clock stays high
    evt.stop = pin_sync[0] & scl_prev & ~sda_prev & pin_sync[1];
    // Data bit as it stands at the seen clock rise
    evt.sda = pin_sync[1];
  end

  // Byte engine: address match, acknowledge, byte delivery
  vxc_i2c_rx u_rx (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .evt(evt),
    .addr_sel(pin_sync[3:2]), // [R1]
    .rx(rx),
    .ack_drive(ack_drive)
  );

  // Register writes and the decode that follows them
  always_comb begin
    next_reg_ptr = reg_ptr;
    next_route_select_out_1_2 = route_select_out_1_2;
    next_route_select_out_3_4 = route_select_out_3_4;
    next_route_select_out_5_6 = route_select_out_5_6;
    next_input_clamp_or_bias = input_clamp_or_bias;
    next_output_gain_select = output_gain_select;
    // The strobe comes once per whole byte, never for a cut one
    if (rx.strobe) begin
      if (rx.is_reg) begin
        // First byte after the address picks the register [R2]
        next_reg_ptr = rx.data;
      end else if (reg_hit(reg_ptr, `VXC_OFF_ROUTE_12)) begin
        next_route_select_out_1_2 = rx.data; // [R3]
      end else if (reg_hit(reg_ptr, `VXC_OFF_ROUTE_34)) begin
        next_route_select_out_3_4 = rx.data; // [R3]
      end else if (reg_hit(reg_ptr, `VXC_OFF_ROUTE_56)) begin
        next_route_select_out_5_6 = rx.data; // [R3]
      end else if (reg_hit(reg_ptr, `VXC_OFF_CLAMP)) begin
        // Own address, so routing writes never disturb it [R7] [R8]
        next_input_clamp_or_bias = rx.data;
      end else if (reg_hit(reg_ptr, `VXC_OFF_GAIN)) begin
        // Top two bits are unused and dropped [R9]
        next_output_gain_select = rx.data[`VXC_GAIN_MSB:0];
      end else begin
        // Undefined register: byte acknowledged, nothing stored [R11]
        next_reg_ptr = reg_ptr;
      end
    end
    // Odd output in the low nibble, even output in the high [R3]
    next_sel = {next_route_select_out_5_6, next_route_select_out_3_4,
                next_route_select_out_1_2};
    // One selector per output, so one input at most; inputs shared [R5]
    for (int i = 0; i < 6; i++) begin
      next_route[i] = sel_onehot(next_sel[i]); // [R4] [R5]
      next_pwrdn[i] = (next_sel[i] == `VXC_SEL_OFF); // [R6]
    end
  end

  // Register bank; all zero after reset, outputs powered down [R10]
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      reg_ptr <= `VXC_RST_REG;
      route_select_out_1_2 <= `VXC_RST_REG; // [R10]
      route_select_out_3_4 <= `VXC_RST_REG;
      route_select_out_5_6 <= `VXC_RST_REG;
      input_clamp_or_bias <= `VXC_RST_REG;
      output_gain_select <= `VXC_RST_GAIN;
      // No input routed and every amplifier off
      route <= '0;
      pwrdn <= `VXC_RST_PWRDN;
      sda_out <= 1'b0;
    end else begin
      reg_ptr <= next_reg_ptr;
      route_select_out_1_2 <= next_route_select_out_1_2;
      route_select_out_3_4 <= next_route_select_out_3_4;
      route_select_out_5_6 <= next_route_select_out_5_6;
      input_clamp_or_bias <= next_input_clamp_or_bias;
      output_gain_select <= next_output_gain_select;
      // Decode is registered alongside its selectors, never behind
      route <= next_route;
      pwrdn <= next_pwrdn;
      sda_out <= 1'b0;
    end
  end

  // Outputs straight from flops. No path ever drives the data line
  // high or shifts register contents out: the port is write only.
  assign SDA_OUT = sda_out; // [R12]
  assign SDA_OE = ack_drive; // [R14]
  assign OUT_SELECT = {route_select_out_5_6, route_select_out_3_4,
                       route_select_out_1_2};
  assign OUT_ROUTE = route;
  assign OUT_PWRDN = pwrdn;
  assign IN_CLAMP = input_clamp_or_bias;
  assign OUT_GAIN_0DB = output_gain_select;

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_N);

  // Per-output decode checks
  for (genvar g = 0; g < 6; g++) begin : g_chk
    a_route_decode: assert property ( // [R4]
      OUT_ROUTE[g] == sel_onehot(OUT_SELECT[g]))
      else $error("crosspoint does not match selector");
    a_route_single: assert property ( // [R5]
      $onehot0(OUT_ROUTE[g]))
      else $error("output driven by more than one input");
    a_pwrdn_off: assert property ( // [R6]
      OUT_PWRDN[g] == (OUT_SELECT[g] == `VXC_SEL_OFF))
      else $error("power-down does not follow off selector");
    a_pwrdn_idle: assert property ( // [R6]
      OUT_PWRDN[g] |-> OUT_ROUTE[g] == 8'h00)
      else $error("powered-down output still routed");
  end

  a_route_write: assert property ( // [R3]
    (rx.strobe && !rx.is_reg && reg_ptr == `VXC_OFF_ROUTE_34)
    |=> (OUT_SELECT[2] == $past(rx.data[3:0]) &&
         OUT_SELECT[3] == $past(rx.data[7:4])))
    else $error("routing nibbles not stored in place");

  a_route_first_pair: assert property ( // [R3]
    (rx.strobe && !rx.is_reg && reg_ptr == `VXC_OFF_ROUTE_12)
    |=> (OUT_SELECT[0] == $past(rx.data[3:0]) &&
         OUT_SELECT[1] == $past(rx.data[7:4])))
    else $error("first routing pair not stored in place");

  a_route_last_pair: assert property ( // [R3]
    (rx.strobe && !rx.is_reg && reg_ptr == `VXC_OFF_ROUTE_56)
    |=> (OUT_SELECT[4] == $past(rx.data[3:0]) &&
         OUT_SELECT[5] == $past(rx.data[7:4])))
    else $error("last routing pair not stored in place");

  // Register pointer follows the byte after the address
  a_ptr_load: assert property ( // [R2]
    (rx.strobe && rx.is_reg) |=> reg_ptr == $past(rx.data))
    else $error("register address byte not taken");

  // Routing holds while clamp, gain or an unused address is written
  a_route_keep: assert property ( // [R3]
    (rx.strobe && !rx.is_reg && reg_ptr > `VXC_OFF_ROUTE_56)
    |=> ($stable(OUT_SELECT) && $stable(OUT_ROUTE)))
    else $error("routing changed by another write");

  // Gain holds across every other register write
  a_gain_keep: assert property ( // [R9]
    (rx.strobe && !rx.is_reg && reg_ptr != `VXC_OFF_GAIN)
    |=> $stable(OUT_GAIN_0DB))
    else $error("gain bits changed by another write");

  // Acknowledge moves only while the clock is low; a change with the
  // clock high would look like a start or a stop to the master
  a_ack_rise_low: assert property ( // [R14]
    $rose(SDA_OE) |-> !pin_sync[0])
    else $error("acknowledge began while the clock was high");

  a_ack_fall_low: assert property ( // [R14]
    $fell(SDA_OE) |-> !pin_sync[0])
    else $error("acknowledge ended while the clock was high");

  a_clamp_write: assert property ( // [R7]
    (rx.strobe && !rx.is_reg && reg_ptr == `VXC_OFF_CLAMP)
    |=> IN_CLAMP == $past(rx.data))
    else $error("clamp register not written");

  a_clamp_keep: assert property ( // [R8]
    (rx.strobe && !rx.is_reg && reg_ptr != `VXC_OFF_CLAMP)
    |=> $stable(IN_CLAMP))
    else $error("clamp bits changed by another write");

  a_gain_write: assert property ( // [R9]
    (rx.strobe && !rx.is_reg && reg_ptr == `VXC_OFF_GAIN)
    |=> OUT_GAIN_0DB == $past(rx.data[5:0]))
    else $error("gain register not written");

  a_undef_ignored: assert property ( // [R11]
    (rx.strobe && !rx.is_reg && reg_ptr > `VXC_OFF_GAIN)
    |=> ($stable(OUT_SELECT) && $stable(IN_CLAMP) &&
         $stable(OUT_GAIN_0DB)))
    else $error("undefined register changed control state");

  // Unused addresses leave the decoded crosspoint alone as well
  a_undef_route: assert property ( // [R11]
    (rx.strobe && !rx.is_reg && reg_ptr > `VXC_OFF_GAIN)
    |=> ($stable(OUT_ROUTE) && $stable(OUT_PWRDN)))
    else $error("undefined register changed the crosspoint");

  a_whole_byte: assert property ( // [R15]
    !(rx.strobe && !rx.is_reg)
    |=> ($stable(OUT_SELECT) && $stable(IN_CLAMP) &&
         $stable(OUT_GAIN_0DB)))
    else $error("control state changed without a data byte");

  a_reset_clear: assert property ( // [R10]
    $rose(RST_N) |-> (OUT_SELECT == '0 && OUT_PWRDN == `VXC_RST_PWRDN &&
                      IN_CLAMP == `VXC_RST_REG &&
                      OUT_GAIN_0DB == `VXC_RST_GAIN))
    else $error("state not cleared by reset");

endmodule // vxc_regs

`default_nettype wire

// ---- tb/vxc_i2c_master.sv ----
`timescale 1ns/1ps
`default_nettype none

module vxc_i2c_master (
  // System clock paces the serial clock, ten edges per bit
  input wire logic clk,
  // Master pins, data is open drain so 1 means released
  output logic scl,
  output logic sda,
  // Resolved data line
  input wire logic sda_wire
);
  // Idle bus, both lines high
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end

  // Wait whole clock edges
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Data falls while clock is high
  task automatic start_cond();
    sda <= 1'b1;
    tick(3);
    scl <= 1'b1;
    tick(5);
    sda <= 1'b0;
    tick(5);
    scl <= 1'b0;
    tick(2);
  endtask

  // Data rises while clock is high
  task automatic stop_cond();
    sda <= 1'b0;
    tick(3);
    scl <= 1'b1;
    tick(5);
    sda <= 1'b1;
    tick(5);
  endtask

  // MSB first, data moves only while clock is low
  task automatic send_bits(input logic [7:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      sda <= b[7 - i];
      tick(3);
      scl <= 1'b1;
      tick(5);
      scl <= 1'b0;
      tick(2);
    end
  endtask

  // Ninth clock with data released; an ack holds the line low at
  // every edge of the high phase, a short pulse does not count
  task automatic send_byte(input logic [7:0] b, output logic ack);
    send_bits(b, 8);
    sda <= 1'b1;
    tick(3);
    scl <= 1'b1;
    ack = 1'b1;
    for (int i = 0; i < 5; i++) begin
      tick(1);
      ack = ack & (sda_wire === 1'b0);
    end
    scl <= 1'b0;
    tick(2);
  endtask

  // Slave address first, then register address and data
  task automatic write_reg(input logic [7:0] a, input logic [7:0] r,
                           input logic [7:0] d, output logic [2:0] acks);
    start_cond();
    send_byte(a, acks[2]);
    send_byte(r, acks[1]);
    send_byte(d, acks[0]);
    stop_cond();
  endtask
endmodule // vxc_i2c_master

`default_nettype wire

// ---- tb/vxc_regs_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module vxc_regs_tb;
  // Clock, reset and pins
  logic clk_sys;
  logic rst_n;
  logic scl;
  logic sda_m;
  logic sda_in;
  logic sda_out;
  logic sda_oe;
  logic pin_low;
  logic pin_high;
  // Control outputs
  logic [5:0][3:0] out_select;
  logic [5:0][7:0] out_route;
  logic [5:0] out_pwrdn;
  logic [7:0] in_clamp;
  logic [5:0] out_gain_0db;
  // Bookkeeping
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [7:0] exp_reg [0:4];
  logic [2:0] acks;

  // Pull-up on the data line: low when any party pulls it
  assign sda_in = sda_m & ~sda_oe;

  initial clk_sys = 1'b0;
  always #4 clk_sys = ~clk_sys;

  vxc_regs u_dut (
    .CLK_SYS(clk_sys), .RST_N(rst_n), .SCL(scl), .SDA_IN(sda_in),
    .SDA_OUT(sda_out), .SDA_OE(sda_oe), .SLAVE_ADDR_PIN_LOW(pin_low),
    .SLAVE_ADDR_PIN_HIGH(pin_high), .OUT_SELECT(out_select),
    .OUT_ROUTE(out_route), .OUT_PWRDN(out_pwrdn), .IN_CLAMP(in_clamp),
    .OUT_GAIN_0DB(out_gain_0db)
  );

  vxc_i2c_master u_master (
    .clk(clk_sys), .scl(scl), .sda(sda_m), .sda_wire(sda_in)
  );

  // Print counts and verdict, then stop
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Bounded run, a hang counts as a mismatch
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      complete_run();
    end
  end

  // Value comparison with case equality
  task automatic compare(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Expected outputs worked out from the shadow registers
  task automatic check_outputs();
    logic [3:0] sel;
    logic [23:0] e_sel;
    logic [47:0] e_route;
    logic [5:0] e_pd;
    for (int i = 0; i < 6; i++) begin
      sel = exp_reg[i / 2][(i % 2) * 4 +: 4];
      e_sel[i * 4 +: 4] = sel;
      e_route[i * 8 +: 8] = (sel != 4'h0 && sel <= 4'h8) ?
                            8'h01 << (sel - 4'h1) : 8'h00;
      e_pd[i] = (sel == 4'h0);
    end
    compare(64'(out_select), 64'(e_sel));
    compare(64'(out_route), 64'(e_route));
    compare(64'(out_pwrdn), 64'(e_pd));
    compare(64'(in_clamp), 64'(exp_reg[3]));
    compare(64'(out_gain_0db), 64'(exp_reg[4][5:0]));
    // Bus is idle here, so the data line must be left released
    compare(64'({sda_oe, sda_out}), 64'(2'b00));
  endtask

  // Reset held ten cycles, shadow registers back to zero
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int i = 0; i < 5; i++) exp_reg[i] = 8'h00;
    repeat (4) @(posedge clk_sys);
  endtask

  // Addressed write, all three bytes must be acknowledged
  task automatic wr(input logic [7:0] r, input logic [7:0] d);
    u_master.write_reg({pin_high, pin_low, 6'h06}, r, d, acks);
    compare(64'(acks), 64'(3'b111));
    if (r <= 8'h04) exp_reg[r[2:0]] = d;
    check_outputs();
  endtask

  initial begin
    rst_n = 1'b0;
    pin_low = 1'b0;
    pin_high = 1'b0;
    do_reset();
    check_outputs();
    // Every strap setting answers its own address
    for (int k = 0; k < 4; k++) begin
      pin_low <= k[0];
      pin_high <= k[1];
      repeat (4) @(posedge clk_sys);
      wr(8'h00, 8'(8'h10 + k));
      // Neighbouring address and read bit are refused
      u_master.write_reg({~pin_high, pin_low, 6'h06}, 8'h00, 8'h77,
                         acks);
      compare(64'(acks), 64'(3'b000));
      u_master.write_reg({pin_high, pin_low, 6'h07}, 8'h00, 8'h77,
                         acks);
      compare(64'(acks), 64'(3'b000));
      check_outputs();
    end
    // Selector codes zero to nine, both nibbles of one register
    for (int c = 0; c < 10; c++) begin
      wr(8'h01, {4'(c), 4'(9 - c)});
    end
    // Codes above eight route nothing and leave the amplifier on
    wr(8'h02, 8'hFA);
    // All outputs share input three
    for (int r = 0; r < 3; r++) wr(8'(r), 8'h33);
    // Clamp bits survive routing writes
    wr(8'h03, 8'hA5);
    wr(8'h00, 8'h12);
    wr(8'h02, 8'h00);
    // Gain with unused top bits set
    wr(8'h04, 8'hFF);
    wr(8'h04, 8'h96);
    // Unmapped addresses acknowledged without effect
    wr(8'h05, 8'hFF);
    wr(8'hFF, 8'h5A);
    // Stop after half a data byte changes nothing
    u_master.start_cond();
    u_master.send_byte({pin_high, pin_low, 6'h06}, acks[2]);
    u_master.send_byte(8'h00, acks[1]);
    u_master.send_bits(8'hFF, 4);
    u_master.stop_cond();
    compare(64'(acks[2:1]), 64'(2'b11));
    check_outputs();
    // Second reset in mid-run
    do_reset();
    check_outputs();
    complete_run();
  end
endmodule // vxc_regs_tb

`default_nettype wire
